/* opsq_pkg.sv */
/*
  package for the oled power and reset sequencer: reset values of the
  driver state and the supply settling times.
  assumes a 100 MHz ref_clk.
*/
package opsq_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned VHV_SETTLE_MS  = 200;
  localparam int unsigned VHV_DRAIN_MS   = 100;
  localparam int unsigned VHV_SETTLE_CYC = VHV_SETTLE_MS * 1000 * CLK_MHZ;
  localparam int unsigned VHV_DRAIN_CYC  = VHV_DRAIN_MS * 1000 * CLK_MHZ;
  localparam logic [7:0]  CONTRAST_RST   = 8'h7F;
  localparam logic [6:0]  COL_RST        = 7'h00;
  localparam logic [6:0]  START_LINE_RST = 7'h00;
  localparam logic [1:0]  MODE_480X128   = 2'h0;
  localparam logic [1:0]  MODE_256X64    = 2'h1;
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_LOGIC   = 3'b001,
    ST_SETTLE  = 3'b010,
    ST_ON      = 3'b011,
    ST_DRAIN   = 3'b100
  } opsq_state_t;
endpackage

/* opsq_cfg_if.sv */
/*
  interface carrying the driver's configuration state from the
  configuration register module to the sequencer top.
  assumes both ends sit on the same ref_clk.
*/
`timescale 1ns/1ps
interface opsq_cfg_if;
  logic       disp_on;
  logic [1:0] disp_mode;
  logic       seg_remap;
  logic       com_remap;
  logic       com_scan_rev;
  logic [6:0] start_line;
  logic [6:0] col_addr;
  logic [7:0] contrast;
  modport regs (output disp_on, disp_mode, seg_remap, com_remap,
                output com_scan_rev, start_line, col_addr, contrast);
  modport user (input disp_on, disp_mode, seg_remap, com_remap,
                input com_scan_rev, start_line, col_addr, contrast);
endinterface

/* opsq_cfg_regs.sv */
/*
  configuration registers of the display driver, forced to their reset
  values while the synchronised hardware init input is low.
  assumes hw_init_low_s is already synchronised to ref_clk.
*/
`timescale 1ns/1ps
module opsq_cfg_regs
  import opsq_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic       hw_init_low_s,
  input  wire logic       wr_en,
  input  wire logic [3:0] wr_sel,
  input  wire logic [7:0] wr_data,
  input  wire logic       col_inc,
  opsq_cfg_if.regs        cfg
);
  logic       init_now;
  assign init_now = reset | ~hw_init_low_s;

  always_ff @(posedge ref_clk) begin
    if (init_now) begin
      cfg.disp_on      <= 1'b0;            // R5
      cfg.disp_mode    <= MODE_480X128;    // R5
      cfg.seg_remap    <= 1'b0;            // R6
      cfg.com_remap    <= 1'b0;            // R6
      cfg.start_line   <= START_LINE_RST;  // R7
      cfg.col_addr     <= COL_RST;         // R8
      cfg.com_scan_rev <= 1'b0;            // R9
      cfg.contrast     <= CONTRAST_RST;    // R10
    end else if (clk_en) begin
      if (wr_en && wr_sel == 4'h0) cfg.disp_on <= wr_data[0];
      if (wr_en && wr_sel == 4'h1) cfg.disp_mode <= wr_data[1:0];
      if (wr_en && wr_sel == 4'h2) cfg.seg_remap <= wr_data[0];
      if (wr_en && wr_sel == 4'h3) cfg.com_remap <= wr_data[0];
      if (wr_en && wr_sel == 4'h4) cfg.start_line <= wr_data[6:0];
      if (wr_en && wr_sel == 4'h6) cfg.com_scan_rev <= wr_data[0];
      if (wr_en && wr_sel == 4'h7) cfg.contrast <= wr_data;
      if (wr_en && wr_sel == 4'h5) begin
        cfg.col_addr <= wr_data[6:0];
      end else if (col_inc) begin
        cfg.col_addr <= cfg.col_addr + 7'h01;
      end
    end
  end

  a_contrast_reset: assert property ( // R10
    @(posedge ref_clk)
    $fell(init_now) |-> cfg.contrast == CONTRAST_RST)
    else $error("contrast not at reset value after init");
  a_col_reset: assert property ( // R8
    @(posedge ref_clk)
    $fell(init_now) |-> cfg.col_addr == COL_RST)
    else $error("column counter not cleared after init");
endmodule

/* opsq_top.sv */
/*
  power and reset sequencer of an oled display driver: tracks supply
  order, times high-voltage settle and discharge, and holds the driver
  configuration state that hardware init restores.
  assumes supply and init pins arrive asynchronous; commands come from
  logic on ref_clk.
*/
// Function
// R1: host enables logic and io supplies, display off, init, clear, then hv.
// R2: host waits 200 ms after hv enable before display on.
// R3: host sends off, drops hv, waits 100 ms, then drops logic supplies.
// R4: host leaves hv supply disabled and floating while it is off.
// R5: init low forces display off and 480x128 mode.
// R6: init restores normal segment and common address mapping at 00h.
// R7: init sets display start line to memory address 0.
// R8: init clears the column address counter to 0.
// R9: init selects normal common output scan direction.
// R10: init loads contrast setting with 7Fh.
// R11: host should apply hardware reset when noise corrupts the image.
// R12: after init release host repeats the full power-up command order.
`timescale 1ns/1ps
module opsq_top
  import opsq_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = VHV_SETTLE_CYC,
  parameter int unsigned DRAIN_CYC  = VHV_DRAIN_CYC
)(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic       hw_init_low,
  input  wire logic       logic_core_supply,
  input  wire logic       io_level_supply,
  input  wire logic       hv_supply,
  input  wire logic       cmd_valid,
  input  wire logic [3:0] cmd_sel,
  input  wire logic [7:0] cmd_data,
  input  wire logic       col_inc,
  output logic            panel_lit,
  output logic            hv_ready,
  output logic            seq_error,
  output logic [2:0]      seq_state,
  output logic            disp_on,
  output logic [1:0]      disp_mode,
  output logic            seg_remap,
  output logic            com_remap,
  output logic            com_scan_rev,
  output logic [6:0]      start_line,
  output logic [6:0]      col_addr,
  output logic [7:0]      contrast
);
  logic [3:0]  sync1_q;
  logic [3:0]  sync2_q;
  logic        init_s;
  logic        logic_s;
  logic        hv_s;
  logic        cmd_ok;
  logic        on_cmd;
  logic        err_d;
  logic        err_q;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  opsq_state_t state_q;
  opsq_state_t state_d;
  opsq_cfg_if  cfg ();

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else if (clk_en) begin
      sync1_q <= {hw_init_low, logic_core_supply, io_level_supply, hv_supply};
      sync2_q <= sync1_q;
    end
  end

  assign init_s  = sync2_q[3];
  assign logic_s = sync2_q[2] & sync2_q[1];
  assign hv_s    = sync2_q[0];

  // display-on allowed only after hv has settled
  assign on_cmd = cmd_valid & (cmd_sel == 4'h0) & cmd_data[0];
  assign cmd_ok = cmd_valid & ~(on_cmd & (state_q != ST_ON)); // R2

  opsq_cfg_regs u_regs (
    .ref_clk       (ref_clk),
    .reset         (reset),
    .clk_en        (clk_en),
    .hw_init_low_s (init_s),
    .wr_en         (cmd_ok),
    .wr_sel        (cmd_sel),
    .wr_data       (cmd_data),
    .col_inc       (col_inc),
    .cfg           (cfg)
  );

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    err_d   = err_q;
    case (state_q)
      ST_OFF: begin
        if (hv_s) err_d = 1'b1;
        if (logic_s) state_d = ST_LOGIC;
      end
      ST_LOGIC: begin
        if (!logic_s) begin
          state_d = ST_OFF;
        end else if (hv_s) begin
          if (cfg.disp_on) err_d = 1'b1; // R1
          state_d = ST_SETTLE;
          cnt_d   = 32'h0;
        end
      end
      ST_SETTLE: begin
        cnt_d = cnt_q + 32'h1;
        if (!logic_s) err_d = 1'b1; // R3
        if (!hv_s) begin
          state_d = ST_DRAIN;
          cnt_d   = 32'h0;
        end else if (cnt_q >= SETTLE_CYC - 1) begin
          state_d = ST_ON; // R2
        end
      end
      ST_ON: begin
        if (!logic_s) err_d = 1'b1; // R3
        if (!hv_s) begin
          if (cfg.disp_on) err_d = 1'b1; // R3
          state_d = ST_DRAIN;
          cnt_d   = 32'h0;
        end
      end
      ST_DRAIN: begin
        cnt_d = cnt_q + 32'h1;
        if (!logic_s && cnt_q < DRAIN_CYC - 1) err_d = 1'b1; // R3
        if (hv_s) err_d = 1'b1;
        if (cnt_q >= DRAIN_CYC - 1) state_d = ST_LOGIC; // R3
      end
      default: state_d = ST_OFF;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ST_OFF;
      cnt_q   <= 32'h0;
      err_q   <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      err_q   <= err_d;
    end
  end

  assign hv_ready     = (state_q == ST_ON);
  assign seq_error    = err_q;
  assign seq_state    = state_q;
  assign panel_lit    = cfg.disp_on & hv_ready;
  assign disp_on      = cfg.disp_on;
  assign disp_mode    = cfg.disp_mode;
  assign seg_remap    = cfg.seg_remap;
  assign com_remap    = cfg.com_remap;
  assign com_scan_rev = cfg.com_scan_rev;
  assign start_line   = cfg.start_line;
  assign col_addr     = cfg.col_addr;
  assign contrast     = cfg.contrast;

  a_init_forces_off: assert property ( // R5
    @(posedge ref_clk) disable iff (reset)
    !init_s |=> !disp_on && disp_mode == MODE_480X128)
    else $error("init low did not force display off and mode");
  a_init_mapping: assert property ( // R6
    @(posedge ref_clk) disable iff (reset)
    !init_s |=> !seg_remap && !com_remap)
    else $error("init low did not restore address mapping");
  a_init_start: assert property ( // R7
    @(posedge ref_clk) disable iff (reset)
    !init_s |=> start_line == START_LINE_RST)
    else $error("init low did not reset start line");
  a_init_col: assert property ( // R8
    @(posedge ref_clk) disable iff (reset)
    !init_s ##1 init_s |-> col_addr == COL_RST)
    else $error("column counter not zero at init release");
  a_init_scan: assert property ( // R9
    @(posedge ref_clk) disable iff (reset)
    !init_s |=> !com_scan_rev)
    else $error("init low did not select normal scan");
  a_init_contrast: assert property ( // R10
    @(posedge ref_clk) disable iff (reset)
    !init_s |=> contrast == CONTRAST_RST)
    else $error("init low did not load contrast");
  a_settle_wait: assert property ( // R2
    @(posedge ref_clk) disable iff (reset)
    $rose(hv_ready) |-> $past(state_q) == ST_SETTLE
      && $past(cnt_q) >= SETTLE_CYC - 1)
    else $error("hv ready before settle time");
  a_on_needs_ready: assert property ( // R2
    @(posedge ref_clk) disable iff (reset)
    $rose(disp_on) |-> $past(hv_ready))
    else $error("display turned on before hv settled");
  a_settle_start: assert property ( // R2
    @(posedge ref_clk) disable iff (reset)
    state_q == ST_LOGIC && logic_s && hv_s && clk_en
      |=> state_q == ST_SETTLE && cnt_q == 32'h0)
    else $error("settle count did not start at hv enable");
  a_drain_start: assert property ( // R3
    @(posedge ref_clk) disable iff (reset)
    state_q == ST_ON && !hv_s && clk_en
      |=> state_q == ST_DRAIN && cnt_q == 32'h0)
    else $error("discharge wait did not start at hv disable");
  a_drain_hold: assert property ( // R3
    @(posedge ref_clk) disable iff (reset)
    state_q == ST_DRAIN && cnt_q < DRAIN_CYC - 1 && clk_en
      |=> state_q == ST_DRAIN)
    else $error("discharge wait ended early");
  a_hv_in_off: assert property ( // R1
    @(posedge ref_clk) disable iff (reset)
    state_q == ST_OFF && hv_s && clk_en |=> seq_error)
    else $error("hv without logic supplies not flagged");
  a_freeze_hold: assert property (
    @(posedge ref_clk) disable iff (reset)
    !clk_en && !reset
      |=> $stable(state_q) && $stable(cnt_q) && $stable(seq_error))
    else $error("sequencer state moved while clock enable low");
endmodule

/* opsq_host_model.sv */
/*
  host model: drives the supply enables and the command writes.
  assumes the sequencer samples these inputs on ref_clk.
*/
`timescale 1ns/1ps
module opsq_host_model
  import opsq_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = 20,
  parameter int unsigned DRAIN_CYC  = 10
)(
  input  wire logic  ref_clk,
  output logic       logic_core_supply,
  output logic       io_level_supply,
  output logic       hv_supply,
  output logic       cmd_valid,
  output logic [3:0] cmd_sel,
  output logic [7:0] cmd_data
);
  initial begin
    logic_core_supply = 1'b0;
    io_level_supply   = 1'b0;
    hv_supply         = 1'b0;
    cmd_valid         = 1'b0;
    cmd_sel           = 4'hF;
    cmd_data          = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // one idle cycle with flipped data after every write
  task automatic send(input logic [3:0] sel, input logic [7:0] data);
    cmd_sel   = sel;
    cmd_data  = data;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    cmd_data  = ~data;
    tick(1);
  endtask
  // display off, init and clear before the high voltage
  task automatic logic_up();
    logic_core_supply = 1'b1;
    io_level_supply   = 1'b1;
    tick(4);
    send(4'h0, 8'h00);
    send(4'h6, 8'h00);
    send(4'h5, 8'h00);
  endtask
  task automatic hv_up();
    hv_supply = 1'b1;
  endtask
  task automatic power_down();
    send(4'h0, 8'h00);
    hv_supply = 1'b0;
    tick(DRAIN_CYC + 8);
    logic_core_supply = 1'b0;
    io_level_supply   = 1'b0;
    tick(4);
  endtask
endmodule

/* test_oled_power_reset_sequencer.sv */
/*
  testbench of the oled power and reset sequencer.
  assumes opsq_host_model plays the host; short settle and drain counts.
*/
`timescale 1ns/1ps
module test_oled_power_reset_sequencer
  import opsq_pkg::*;
;
  logic ref_clk = 1'b0, reset = 1'b1, hw_init_low = 1'b0, col_inc = 1'b0;
  logic clk_en = 1'b1;
  logic core_s, io_s, hv_s, cmd_valid, panel_lit, hv_ready, seq_error;
  logic disp_on, seg_remap, com_remap, com_scan_rev;
  logic [3:0]  cmd_sel;
  logic [7:0]  cmd_data, contrast, r8;
  logic [1:0]  disp_mode;
  logic [2:0]  seq_state;
  logic [6:0]  start_line, col_addr;
  logic [31:0] lfsr_q = 32'h0001243A;
  int num_errors = 0, tests_run = 0;
  always #5 ref_clk = ~ref_clk;
  opsq_top #(.SETTLE_CYC(20), .DRAIN_CYC(10)) dut (.ref_clk(ref_clk),
    .reset(reset), .clk_en(clk_en), .hw_init_low(hw_init_low),
    .logic_core_supply(core_s), .io_level_supply(io_s), .hv_supply(hv_s),
    .cmd_valid(cmd_valid), .cmd_sel(cmd_sel), .cmd_data(cmd_data),
    .col_inc(col_inc), .panel_lit(panel_lit), .hv_ready(hv_ready),
    .seq_error(seq_error), .seq_state(seq_state), .disp_on(disp_on),
    .disp_mode(disp_mode), .seg_remap(seg_remap), .com_remap(com_remap),
    .com_scan_rev(com_scan_rev), .start_line(start_line),
    .col_addr(col_addr), .contrast(contrast));
  opsq_host_model #(.SETTLE_CYC(20), .DRAIN_CYC(10)) host (
    .ref_clk(ref_clk), .logic_core_supply(core_s), .io_level_supply(io_s),
    .hv_supply(hv_s), .cmd_valid(cmd_valid), .cmd_sel(cmd_sel),
    .cmd_data(cmd_data));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_defaults();
    chk(8'(disp_on), 8'h00);
    chk(8'(panel_lit), 8'h00);
    chk(8'(disp_mode), 8'(MODE_480X128));
    chk(8'(seg_remap), 8'h00);
    chk(8'(com_remap), 8'h00);
    chk(8'(start_line), 8'(START_LINE_RST));
    chk(8'(col_addr), 8'(COL_RST));
    chk(8'(com_scan_rev), 8'h00);
    chk(contrast, CONTRAST_RST);
  endtask
  task automatic wait_ready();
    int n;
    for (n = 0; n < 40 && hv_ready !== 1'b1; n++) host.tick(1);
    if (n == 40) begin
      num_errors++;
      close_out();
    end
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    chk_defaults();
    hw_init_low = 1'b1;
    host.logic_up();
    host.send(4'h0, 8'h01);
    chk(8'(disp_on), 8'h00);
    host.hv_up();
    host.tick(20);
    chk(8'(hv_ready), 8'h00);
    wait_ready();
    chk(8'(seq_state), 8'(ST_ON));
    host.send(4'h0, 8'h01);
    chk(8'(panel_lit), 8'h01);
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      r8 = lfsr_q[7:0];
      clk_en = 1'b0;
      host.send(4'h7, r8);
      chk(contrast, CONTRAST_RST);
      clk_en = 1'b1;
      host.send(4'h7, r8);
      chk(contrast, r8);
      host.send(4'h4, r8);
      host.send(4'h5, r8);
      col_inc = 1'b1;
      host.tick(1);
      col_inc = 1'b0;
      chk(8'(start_line), {1'b0, r8[6:0]});
      chk(8'(col_addr), {1'b0, r8[6:0] + 7'h01});
      for (int s = 1; s < 4; s++) host.send(4'(s), 8'h01);
      host.send(4'h6, 8'h01);
      hw_init_low = 1'b0;
      host.tick(4);
      chk_defaults();
      hw_init_low = 1'b1;
      host.logic_up();
      host.send(4'h0, 8'h01);
      chk(8'(panel_lit), 8'h01);
    end
    host.power_down();
    chk(8'(hv_ready), 8'h00);
    chk(8'(seq_state), 8'(ST_OFF));
    chk(8'(seq_error), 8'h00);
    host.hv_up();
    host.tick(4);
    chk(8'(seq_error), 8'h01);
    close_out();
  end
endmodule
